// ===== hw/isqe_engine.sv
// Sequence engine with host registers and one bidirectional I2C channel.
// Assumes the host strobes stay low at least three sys_clk cycles and
// the I2C pins are resolved as open drain by the surrounding pads.
`default_nettype none
`timescale 1ns/100ps
module isqe_engine (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ce_b,
  input wire logic rd_b,
  input wire logic wr_b,
  input wire logic [isqe_pkg::AW-1:0] addr,
  input wire logic [isqe_pkg::DW-1:0] data_i,
  output logic [isqe_pkg::DW-1:0] data_o,
  output logic data_oe,
  output logic int_b,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);
  import isqe_pkg::*;

  logic [1:0] rst_pipe; // Reset release chain.
  logic rst_core_b; // Reset used by all other logic.
  logic soft_go; // One-cycle global soft reset.
  logic [20:0] sy1, sy2; // Pin synchronisers.
  logic s_ce, s_rd, s_wr, s_scl, s_sda;
  logic [7:0] s_addr, s_dat;
  logic rd_prev, wr_prev, rd_act, rd_ev, wr_ev;
  logic [7:0] init_cnt; // Settle counter.
  logic init_busy; // High while initializing.
  logic armed; // First key seen.
  logic [7:0] ctrl, cim; // Control and interrupt mask.
  logic [7:0] sla [NT]; // Slave address table.
  logic [7:0] len [NT]; // Transaction lengths.
  logic [1:0] tst [NT]; // Per-transaction status.
  logic [7:0] dbuf [NB]; // Data buffer.
  logic [2:0] chst; // Channel status.
  logic pend; // Channel interrupt pending.
  logic pin_lo; // Level driven when a pin is enabled.
  isqe_state_type state;
  logic [1:0] phase, idx;
  logic [3:0] qcnt, bitn, ptr;
  logic [7:0] sh, bcnt, next_rdata;
  logic is_addr, ack_n, aborted, tick, rnw;
  logic rx_byte, byte_end, nack_err, cont_err, abort, tr_end;
  logic last_byte, seq_end, sta_go, pend_set;

  // Release reset through two flops; a soft reset pulls the chain low.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_pipe <= 2'h0;
    end else if (soft_go) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_core_b = rst_pipe[1];

  // All pins cross into sys_clk through two flops before use.
  always_ff @(posedge sys_clk or negedge rst_core_b) begin
    if (!rst_core_b) begin
      sy1 <= SYNC_RST;
      sy2 <= SYNC_RST;
    end else begin
      sy1 <= {ce_b, rd_b, wr_b, scl_i, sda_i, addr, data_i};
      sy2 <= sy1;
    end
  end
  assign {s_ce, s_rd, s_wr, s_scl, s_sda, s_addr, s_dat} = sy2;

  // Strobe history; an access is taken on the falling strobe.
  always_ff @(posedge sys_clk or negedge rst_core_b) begin
    if (!rst_core_b) begin
      rd_prev <= 1'b1;
      wr_prev <= 1'b1;
    end else begin
      rd_prev <= s_rd | s_ce;
      wr_prev <= s_wr | s_ce;
    end
  end
  assign rd_act = !s_rd && !s_ce;
  assign rd_ev = rd_act && rd_prev;
  assign wr_ev = !s_wr && !s_ce && wr_prev;

  // Settle timer stands for the oscillator and PLL start-up.
  // Only the global resets restart it; there is no other reset here.
  always_ff @(posedge sys_clk or negedge rst_core_b) begin
    if (!rst_core_b) begin
      init_cnt <= 8'h00;
      init_busy <= 1'b1;
    end else if (init_busy) begin
      init_cnt <= init_cnt + 8'h01;
      if (init_cnt == INIT_CYC - 8'h01) begin
        init_busy <= 1'b0;
      end
    end
  end

  // Key pair detector; any other access in between disarms it.
  always_ff @(posedge sys_clk or negedge rst_core_b) begin
    if (!rst_core_b) begin
      armed <= 1'b0;
      soft_go <= 1'b0;
    end else begin
      soft_go <= armed && wr_ev && s_addr == A_SRST
        && s_dat == KEY2;
      if (wr_ev || rd_ev) begin
        armed <= wr_ev && s_addr == A_SRST && s_dat == KEY1;
      end
    end
  end

  // Control and mask registers; the start bit drops at sequence end.
  // A host write in that same cycle wins, so a restart is not lost.
  always_ff @(posedge sys_clk or negedge rst_core_b) begin
    if (!rst_core_b) begin
      ctrl <= REG_RST;
      cim <= REG_RST;
    end else begin
      if (wr_ev && s_addr == A_CTRL) begin
        ctrl <= s_dat;
      end else if (seq_end) begin
        ctrl[C_STA] <= 1'b0;
      end
      if (wr_ev && s_addr == A_CIM) begin
        cim <= s_dat;
      end
    end
  end

  // Tables per transaction; status is rebuilt on every start.
  for (genvar gi = 0; gi < NT; gi++) begin : g_tr
    always_ff @(posedge sys_clk or negedge rst_core_b) begin
      if (!rst_core_b) begin
        sla[gi] <= REG_RST;
        len[gi] <= REG_RST;
        tst[gi] <= 2'h0;
      end else begin
        if (wr_ev && s_addr == A_SLA + 8'(gi)) begin
          sla[gi] <= s_dat;
        end
        if (wr_ev && s_addr == A_LEN + 8'(gi)) begin
          len[gi] <= s_dat;
        end
        if (sta_go) begin
          tst[gi] <= 2'h0;
        end else if (byte_end && idx == 2'(gi)) begin
          if (nack_err) begin
            tst[gi][0] <= 1'b1;
          end
          if (tr_end) begin
            tst[gi][1] <= 1'b1;
          end
        end
      end
    end
  end

  // Buffer bytes; a received byte lands at the end of its acknowledge bit.
  for (genvar gb = 0; gb < NB; gb++) begin : g_buf
    always_ff @(posedge sys_clk or negedge rst_core_b) begin
      if (!rst_core_b) begin
        dbuf[gb] <= REG_RST;
      end else if (byte_end && rx_byte && ptr == 4'(gb)) begin
        dbuf[gb] <= sh;
      end else if (wr_ev && s_addr == A_BUF + 8'(gb)) begin
        dbuf[gb] <= s_dat;
      end
    end
  end

  // Engine decode terms.
  assign rnw = sla[idx][7];
  assign rx_byte = !is_addr && rnw;
  assign byte_end = tick && state == SQ_BYTE && phase == 2'h3
    && bitn == 4'h8;
  assign cont_err = ctrl[C_WEM] && ctrl[C_REM];
  assign nack_err = byte_end && !rx_byte && ack_n;
  assign abort = nack_err && !cont_err;
  assign last_byte = (bcnt + 8'h01) == len[idx];
  // Sizes are never checked; a zero length ends after the address.
  assign tr_end = byte_end && (nack_err ? cont_err
    : (is_addr ? len[idx] == 8'h00 : last_byte));
  assign seq_end = tick && state == SQ_STOP && phase == 2'h3;
  assign sta_go = state == SQ_IDLE && ctrl[C_STA] && !init_busy;
  assign pend_set = seq_end && (aborted || !ctrl[C_SDM]);

  // Quarter-bit divider; it rests while idle.
  always_ff @(posedge sys_clk or negedge rst_core_b) begin
    if (!rst_core_b) begin
      qcnt <= 4'h0;
    end else if (state == SQ_IDLE || tick) begin
      qcnt <= 4'h0;
    end else begin
      qcnt <= qcnt + 4'h1;
    end
  end
  assign tick = qcnt == QTR_CYC - 4'h1;

  // Bit engine: each bit has four quarters, low, rise, sample, fall.
  // A slave that holds SCL low stalls the rise quarter.
  always_ff @(posedge sys_clk or negedge rst_core_b) begin
    if (!rst_core_b) begin
      state <= SQ_IDLE;
      phase <= 2'h0;
      idx <= 2'h0;
      bitn <= 4'h0;
      ptr <= 4'h0;
      sh <= 8'h00;
      bcnt <= 8'h00;
      is_addr <= 1'b0;
      ack_n <= 1'b0;
      aborted <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else if (state == SQ_IDLE) begin
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      phase <= 2'h0;
      if (sta_go) begin
        state <= SQ_START;
        idx <= 2'h0;
        ptr <= 4'h0;
        aborted <= 1'b0;
      end
    end else if (tick) begin
      if (!(phase == 2'h1 && !s_scl)) begin
        phase <= phase + 2'h1;
      end
      case (state)
        SQ_START: begin
          // Same steps serve START and repeated START.
          case (phase)
            2'h0: sda_oe <= 1'b0;
            2'h1: scl_oe <= 1'b0;
            2'h2: sda_oe <= 1'b1;
            default: begin
              scl_oe <= 1'b1;
              state <= SQ_BYTE;
              bitn <= 4'h0;
              is_addr <= 1'b1;
              sh <= {sla[idx][6:0], sla[idx][7]};
            end
          endcase
        end
        SQ_BYTE: begin
          case (phase)
            2'h0: begin
              // Master acks each read byte but the last.
              if (bitn == 4'h8) begin
                sda_oe <= rx_byte && !last_byte;
              end else begin
                sda_oe <= !rx_byte && !sh[7];
              end
            end
            2'h1: scl_oe <= 1'b0;
            2'h2: begin
              if (bitn == 4'h8) begin
                ack_n <= s_sda;
              end else begin
                sh <= {sh[6:0], s_sda};
              end
            end
            default: begin
              scl_oe <= 1'b1;
              bitn <= bitn + 4'h1;
              if (bitn == 4'h8) begin
                bitn <= 4'h0;
                if (rx_byte) begin
                  ptr <= ptr + 4'h1;
                end
                if (abort) begin
                  state <= SQ_STOP;
                  aborted <= 1'b1;
                end else if (tr_end) begin
                  // Transactions run in table order.
                  if (idx == ctrl[C_LAST+1:C_LAST]) begin
                    state <= SQ_STOP;
                  end else begin
                    idx <= idx + 2'h1;
                    state <= SQ_START;
                  end
                end else begin
                  is_addr <= 1'b0;
                  bcnt <= is_addr ? 8'h00 : bcnt + 8'h01;
                  if (!rnw) begin
                    sh <= dbuf[ptr];
                    ptr <= ptr + 4'h1;
                  end
                end
              end
            end
          endcase
        end
        SQ_STOP: begin
          case (phase)
            2'h0: sda_oe <= 1'b1;
            2'h1: scl_oe <= 1'b0;
            2'h2: sda_oe <= 1'b0;
            default: state <= SQ_IDLE;
          endcase
        end
        default: state <= SQ_IDLE;
      endcase
    end
  end

  // Channel flags; a new start clears them.
  always_ff @(posedge sys_clk or negedge rst_core_b) begin
    if (!rst_core_b) begin
      chst <= 3'h0;
    end else if (sta_go) begin
      chst <= 3'h0;
    end else begin
      if (seq_end && !aborted) begin
        chst[ST_SD] <= 1'b1;
      end
      if (nack_err) begin
        chst[rnw ? ST_RE : ST_WE] <= 1'b1;
      end
    end
  end

  // Pending request; set only at sequence end, so it always comes
  // with a nonzero status, and a set beats the read clear.
  always_ff @(posedge sys_clk or negedge rst_core_b) begin
    if (!rst_core_b) begin
      pend <= 1'b0;
    end else if (pend_set) begin
      pend <= 1'b1;
    end else if (sta_go || (rd_ev && s_addr == A_CHST)) begin
      pend <= 1'b0;
    end
  end

  // Interrupt pin, active low, held high while masked.
  always_ff @(posedge sys_clk or negedge rst_core_b) begin
    if (!rst_core_b) begin
      int_b <= 1'b1;
    end else begin
      int_b <= !(pend && !cim[0]);
    end
  end

  // Read multiplexer; it has no side effects of its own.
  always_comb begin
    next_rdata = 8'h00;
    case (s_addr)
      A_ID: next_rdata = {ID_FAMILY, ID_CODE};
      A_RDY: next_rdata = init_busy ? RDY_INIT : RDY_RUN;
      A_CST: next_rdata = {4'h0, state != SQ_IDLE, 2'h0, pend};
      A_CIM: next_rdata = cim;
      A_CHST: next_rdata = {5'h00, chst};
      A_CTRL: next_rdata = ctrl;
      default: begin
        if (s_addr[7:2] == A_SLA[7:2]) begin
          next_rdata = sla[s_addr[1:0]];
        end else if (s_addr[7:2] == A_LEN[7:2]) begin
          next_rdata = len[s_addr[1:0]];
        end else if (s_addr[7:2] == A_TST[7:2]) begin
          next_rdata = {6'h00, tst[s_addr[1:0]]};
        end else if (s_addr[7:4] == A_BUF[7:4]) begin
          next_rdata = dbuf[s_addr[3:0]];
        end
      end
    endcase
  end

  // Read data tracks state for as long as the strobe is low.
  always_ff @(posedge sys_clk or negedge rst_core_b) begin
    if (!rst_core_b) begin
      data_o <= 8'h00;
      data_oe <= 1'b0;
      pin_lo <= 1'b0;
    end else begin
      data_oe <= rd_act;
      pin_lo <= 1'b0;
      if (rd_act) begin
        data_o <= next_rdata;
      end
    end
  end
  assign scl_o = pin_lo;
  assign sda_o = pin_lo;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_core_b);

  sequence s_key2;
    armed && wr_ev && s_addr == A_SRST && s_dat == KEY2;
  endsequence
  sequence s_start_fall;
    state == SQ_START && tick && phase == 2'h2;
  endsequence

  chk_soft_reset_fire: assert property (s_key2 |=> soft_go)
    else $error("Key pair did not trigger reset.");
  chk_soft_reset_guard: assert property (soft_go |-> $past(armed))
    else $error("Soft reset without first key.");
  chk_ready_code: assert property (rd_act && s_addr == A_RDY
    |=> data_o == ($past(init_busy) ? RDY_INIT : RDY_RUN))
    else $error("Ready register value wrong.");
  chk_id_read: assert property (rd_act && s_addr == A_ID
    |=> data_o == {ID_FAMILY, ID_CODE})
    else $error("Identification value wrong.");
  chk_mask_quiet: assert property (cim[0] |=> int_b)
    else $error("Masked channel drove interrupt.");
  chk_pend_clear: assert property (rd_ev && s_addr == A_CHST
    && !pend_set |=> !pend)
    else $error("Status read did not clear request.");
  chk_pend_status: assert property (pend |-> chst != 3'h0)
    else $error("Request with empty status.");
  chk_start_now: assert property (sta_go |=> state == SQ_START)
    else $error("Start bit did not start.");
  chk_start_edge: assert property (s_start_fall
    |=> sda_oe && !scl_oe)
    else $error("START edge not driven.");
  chk_abort_stop: assert property (abort |=> state == SQ_STOP)
    else $error("NACK did not lead to STOP.");
  chk_done_flag: assert property (seq_end && !aborted
    |=> chst[ST_SD])
    else $error("Done flag not set.");
  chk_mid_quiet: assert property (!seq_end |=> !$rose(pend))
    else $error("Request raised mid-sequence.");
endmodule
`default_nettype wire

// ===== hw/isqe_pkg.sv
// Shared constants and types of the I2C sequence engine.
// Assumes a 50 MHz system clock and an 8-bit parallel host bus.
`default_nettype none
package isqe_pkg;
  // Bus widths.
  localparam int AW = 8;
  localparam int DW = 8;
  // Clock and serial rates.
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_NS = 20;
  localparam int SCL_HZ = 1_000_000;
  // Quarter of one serial bit, in system cycles.
  localparam logic [3:0] QTR_CYC = 4'(CLK_HZ / (4 * SCL_HZ));
  // Oscillator and PLL settling time after a global reset.
  localparam int INIT_NS = 1000;
  localparam logic [7:0] INIT_CYC = 8'((INIT_NS + CLK_NS - 1) / CLK_NS);
  // Register offsets.
  localparam logic [7:0] A_SLA = 8'h00;
  localparam logic [7:0] A_LEN = 8'h08;
  localparam logic [7:0] A_TST = 8'h10;
  localparam logic [7:0] A_BUF = 8'h40;
  localparam logic [7:0] A_CHST = 8'hc0;
  localparam logic [7:0] A_CTRL = 8'hc1;
  localparam logic [7:0] A_CST = 8'hf0;
  localparam logic [7:0] A_CIM = 8'hf1;
  localparam logic [7:0] A_ID = 8'hf6;
  localparam logic [7:0] A_SRST = 8'hf7;
  localparam logic [7:0] A_RDY = 8'hff;
  // Table sizes.
  localparam int NT = 4;
  localparam int NB = 16;
  // Soft reset keys and ready codes.
  localparam logic [7:0] KEY1 = 8'ha5;
  localparam logic [7:0] KEY2 = 8'h5a;
  localparam logic [7:0] RDY_INIT = 8'hff;
  localparam logic [7:0] RDY_RUN = 8'h00;
  // Identification; the code value is arbitrary.
  localparam logic ID_FAMILY = 1'b1;
  localparam logic [6:0] ID_CODE = 7'h12;
  // Control register fields.
  localparam int C_STA = 0;
  localparam int C_SDM = 1;
  localparam int C_WEM = 2;
  localparam int C_REM = 3;
  localparam int C_LAST = 4;
  // Channel status fields.
  localparam int ST_SD = 0;
  localparam int ST_WE = 1;
  localparam int ST_RE = 2;
  // Reset values.
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [20:0] SYNC_RST = 21'h1f0000;
  // Engine states.
  typedef enum logic [1:0] {
    SQ_IDLE, SQ_START, SQ_BYTE, SQ_STOP
  } isqe_state_type;
endpackage
`default_nettype wire

// ===== test/isqe_slave_model.sv
// Behavioural I2C slave that answers the engine on its serial wires.
// Assumes the bench resolves both wires as open drain with pull-ups.
`timescale 1ns/100ps
`default_nettype none
module isqe_slave_model #(
  parameter logic [6:0] NACK_ADDR = 7'h33,
  parameter logic [7:0] RD_BYTE = 8'hc6
) (
  input wire logic scl,
  input wire logic sda,
  output logic sda_pull
);
  logic [7:0] got [$]; // Every byte sent to us, address bytes included.
  int n_start = 0; // Count of START and repeated START conditions.
  int n_stop = 0; // Count of STOP conditions.
  int bitn = 0; // Bit position within the current byte.
  logic [7:0] sh = 8'h00; // Shift register for incoming bits.
  logic first = 1'b0; // High while the address byte is on the wire.
  logic reading = 1'b0; // High while we drive read data.
  logic next_rd = 1'b0; // Direction taken from the address byte.
  logic mack = 1'b1; // Level the engine put on the ninth bit.
  initial sda_pull = 1'b0;
  // A falling data line while the clock is high opens a frame.
  always @(negedge sda) begin
    if (scl) begin
      bitn = 0;
      first = 1'b1;
      reading = 1'b0;
      n_start++;
    end
  end
  // A rising data line while the clock is high closes the frame.
  always @(posedge sda) begin
    if (scl) begin
      n_stop++;
    end
  end
  // Bits are taken on the rising clock, most significant first.
  always @(posedge scl) begin
    if (bitn == 8) begin
      mack = sda;
    end
    sh = {sh[6:0], sda};
    bitn++;
  end
  // The data line only moves while the clock is low, so no false frame.
  always @(negedge scl) begin
    if (bitn == 8) begin
      sda_pull = 1'b0;
      if (!reading) begin
        got.push_back(sh);
        sda_pull = !first || sh[7:1] != NACK_ADDR;
        next_rd = first ? sh[0] : next_rd;
      end
    end else if (bitn == 9) begin
      bitn = 0;
      // A high ninth bit from the engine ends our read data.
      reading = first ? next_rd : (reading && !mack);
      first = 1'b0;
      sda_pull = reading && !RD_BYTE[7];
    end else if (reading) begin
      sda_pull = !RD_BYTE[7 - bitn];
    end
  end
endmodule
`default_nettype wire

// ===== test/tb_top.sv
// Self-checking bench of the sequence engine through its host bus.
// Assumes the slave model sits on the open-drain serial wires.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import isqe_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce_b = 1'b1;
  logic rd_b = 1'b1;
  logic wr_b = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] data_i = 8'h00;
  logic [7:0] data_o;
  logic int_b;
  logic scl_oe;
  logic sda_oe;
  logic data_oe; // Read data enable from the design.
  logic scl_o; // Level the design puts on an enabled clock pin.
  logic sda_o; // Level the design puts on an enabled data pin.
  logic oe_q = 1'b0; // Read enable seen when the last access sampled data.
  logic pull;
  wire logic scl_w = ~scl_oe; // Pull-up wins when nobody pulls.
  wire logic sda_w = ~(sda_oe | pull);
  int fail_count = 0;
  int n_tests = 0;
  int n0;
  int s0;
  int p0;

  isqe_engine DUT (.sys_clk(sys_clk), .rst_b(rst_b), .ce_b(ce_b),
    .rd_b(rd_b), .wr_b(wr_b), .addr(addr), .data_i(data_i),
    .data_o(data_o), .data_oe(data_oe), .int_b(int_b), .scl_i(scl_w),
    .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe(sda_oe));
  isqe_slave_model slave (.scl(scl_w), .sda(sda_w), .sda_pull(pull));

  // Free-running 50 MHz clock.
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end

  // Prints the counts and the verdict, then stops the run.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Compares one value and counts it.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One host access; select follows every strobe, which also suits init.
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    @(negedge sys_clk);
    addr = a;
    data_i = d;
    ce_b = 1'b0;
    wr_b = !w;
    rd_b = w;
    repeat (5) @(negedge sys_clk);
    q = data_o;
    oe_q = data_oe;
    ce_b = 1'b1;
    wr_b = 1'b1;
    rd_b = 1'b1;
    // Released lines carry the inverse so stale values cannot pass.
    addr = ~a;
    data_i = ~d;
    repeat (4) @(negedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, a, d, q);
  endtask

  // Reads a register and compares the masked value.
  task automatic rdc(input logic [7:0] a, input logic [7:0] m,
                     input logic [7:0] exp);
    logic [7:0] q;
    acc(1'b0, a, 8'h00, q);
    chk(q & m, exp);
  endtask

  // Polls a register until the masked value matches, with a bound.
  task automatic wait_reg(input logic [7:0] a, input logic [7:0] m,
                          input logic [7:0] exp);
    logic [7:0] q;
    for (int i = 0; i < 400; i++) begin
      acc(1'b0, a, 8'h00, q);
      if ((q & m) === exp) begin
        return;
      end
    end
    // The last poll still differs, so this compare counts the timeout.
    chk(q & m, exp);
    wrap_up();
  endtask

  // Loads two entries, starts, and polls until the channel is idle.
  task automatic run(input logic [7:0] sa0, input logic [7:0] sa1,
                     input logic [7:0] l0, input logic [7:0] l1,
                     input logic [7:0] ctl);
    n0 = slave.got.size();
    s0 = slave.n_start;
    p0 = slave.n_stop;
    wr(A_SLA, sa0);
    wr(A_SLA + 8'h01, sa1);
    wr(A_LEN, l0);
    wr(A_LEN + 8'h01, l1);
    wr(A_CTRL, ctl);
    wait_reg(A_CST, 8'h08, 8'h00);
  endtask

  task automatic t_init();
    rdc(A_RDY, 8'hff, RDY_INIT);
    wait_reg(A_RDY, 8'hff, RDY_RUN);
    wr(A_ID, 8'h00);
    rdc(A_ID, 8'hff, {ID_FAMILY, ID_CODE});
    // The read enable stood while data was taken and dropped after.
    chk({7'h00, oe_q}, 8'h01);
    chk({7'h00, data_oe}, 8'h00);
    // Open-drain pins only ever pull low.
    chk({6'h00, scl_o, sda_o}, 8'h00);
    rdc(A_RDY, 8'hff, RDY_RUN);
    $display("test init done");
  endtask

  // A write entry then a read entry, both one byte.
  task automatic t_seq();
    wr(A_BUF, 8'h3c);
    run(8'h2a, 8'hab, 8'h01, 8'h01, 8'h11);
    chk(8'(slave.got.size() - n0), 8'h03);
    chk(slave.got[n0], 8'h54);
    chk(slave.got[n0 + 1], 8'h3c);
    chk(slave.got[n0 + 2], 8'h57);
    chk(8'(slave.n_start - s0), 8'h02);
    chk(8'(slave.n_stop - p0), 8'h01);
    chk({7'h00, int_b}, 8'h00);
    rdc(A_BUF + 8'h01, 8'hff, 8'hc6);
    rdc(A_CHST, 8'hff, 8'h01);
    chk({7'h00, int_b}, 8'h01);
    // Flags stand until the next start; only the request was cleared.
    rdc(A_CHST, 8'hff, 8'h01);
    chk({7'h00, int_b}, 8'h01);
    $display("test sequence done");
  endtask

  // The first address is refused with errors unmasked.
  task automatic t_nack();
    run(8'h33, 8'h2a, 8'h01, 8'h00, 8'h11);
    chk(8'(slave.got.size() - n0), 8'h01);
    chk(8'(slave.n_stop - p0), 8'h01);
    chk({7'h00, int_b}, 8'h00);
    rdc(A_CST, 8'h01, 8'h01);
    rdc(A_CHST, 8'h03, 8'h02);
    rdc(A_TST, 8'h01, 8'h01);
    $display("test nack done");
  endtask

  // Errors masked and the channel masked at controller level.
  task automatic t_masked();
    wr(A_CIM, 8'h01);
    run(8'h33, 8'h2a, 8'h01, 8'h00, 8'h1d);
    chk(slave.got[slave.got.size() - 1], 8'h54);
    chk(8'(slave.n_stop - p0), 8'h01);
    chk({7'h00, int_b}, 8'h01);
    rdc(A_CST, 8'h01, 8'h01);
    rdc(A_CHST, 8'h03, 8'h03);
    wr(A_CIM, 8'h00);
    // Done mask set: a clean sequence must stay silent.
    run(8'h2a, 8'h2a, 8'h00, 8'h00, 8'h03);
    chk(slave.got[slave.got.size() - 1], 8'h54);
    chk({7'h00, int_b}, 8'h01);
    rdc(A_CHST, 8'h01, 8'h01);
    $display("test masked done");
  endtask

  // A broken key pair is ignored, a clean pair reinitializes.
  task automatic t_soft();
    wr(A_SRST, KEY1);
    rdc(A_ID, 8'hff, {ID_FAMILY, ID_CODE});
    wr(A_SRST, KEY2);
    rdc(A_RDY, 8'hff, RDY_RUN);
    wr(A_SRST, KEY1);
    wr(A_SRST, KEY2);
    rdc(A_RDY, 8'hff, RDY_INIT);
    rdc(A_SLA, 8'hff, REG_RST);
    wait_reg(A_RDY, 8'hff, RDY_RUN);
    $display("test soft reset done");
  endtask

  // Reset for ten cycles, then every scenario in turn.
  initial begin
    repeat (10) @(negedge sys_clk);
    rst_b = 1'b1;
    t_init();
    t_seq();
    t_nack();
    t_masked();
    t_soft();
    wrap_up();
  end
endmodule
`default_nettype wire
